// ### pfs_pkg.sv
// Constants, types and function tables for the pad function selector
package pfs_pkg;

  localparam int PFS_NPAD = 22;
  localparam int PFS_NDIR = 18;
  localparam int PFS_NFUNC = 3;

  // Source codes: 0 none, 1 signal router, 2+n direct peripheral signal n
  localparam logic [4:0] PFS_SRC_NONE = 5'h00;
  localparam logic [4:0] PFS_SRC_ROUTER = 5'h01;
  localparam logic [4:0] PFS_SRC_DIR0 = 5'h02;

  // Direct peripheral signal indices
  localparam int PFS_D_TMS = 0;
  localparam int PFS_D_TDI = 1;
  localparam int PFS_D_TCK = 2;
  localparam int PFS_D_TDO = 3;
  localparam int PFS_D_FL_Q = 4;
  localparam int PFS_D_FL_D = 5;
  localparam int PFS_D_FL_HD = 6;
  localparam int PFS_D_FL_WP = 7;
  localparam int PFS_D_FL_CLK = 8;
  localparam int PFS_D_FL_CS = 9;
  localparam int PFS_D_FS_Q = 10;
  localparam int PFS_D_FS_D = 11;
  localparam int PFS_D_FS_HD = 12;
  localparam int PFS_D_FS_WP = 13;
  localparam int PFS_D_FS_CLK = 14;
  localparam int PFS_D_FS_CS = 15;
  localparam int PFS_D_CON_RX = 16;
  localparam int PFS_D_CON_TX = 17;

  // Capability flags {input, output, high impedance}
  localparam logic [2:0] PFS_CAP_IOT = 3'h7;
  localparam logic [2:0] PFS_CAP_I = 3'h4;
  localparam logic [2:0] PFS_CAP_OT = 3'h3;
  localparam logic [2:0] PFS_CAP_O = 3'h2;
  localparam logic [2:0] PFS_CAP_NONE = 3'h0;

  // Capability per source code
  localparam logic [2:0] PFS_SRC_CAP [0:19] = '{
    PFS_CAP_NONE, PFS_CAP_IOT,
    PFS_CAP_I, PFS_CAP_I, PFS_CAP_I, PFS_CAP_OT,
    PFS_CAP_IOT, PFS_CAP_IOT, PFS_CAP_IOT, PFS_CAP_IOT, PFS_CAP_OT, PFS_CAP_OT,
    PFS_CAP_IOT, PFS_CAP_IOT, PFS_CAP_IOT, PFS_CAP_IOT, PFS_CAP_IOT, PFS_CAP_IOT,
    PFS_CAP_I, PFS_CAP_O
  };

  // Direct inputs held high when their function is not selected; others held low
  localparam logic [PFS_NDIR-1:0] PFS_DIRECT_DFLT_HI = 18'h1FCF7;

  // Source of function zero, one and two for each pad
  localparam logic [4:0] PFS_FUNC_SRC [0:PFS_NPAD-1][0:PFS_NFUNC-1] = '{
    '{5'h01, 5'h01, 5'h00},
    '{5'h01, 5'h01, 5'h00},
    '{5'h01, 5'h01, 5'h0C},
    '{5'h01, 5'h01, 5'h00},
    '{5'h02, 5'h01, 5'h0E},
    '{5'h03, 5'h01, 5'h0F},
    '{5'h04, 5'h01, 5'h10},
    '{5'h05, 5'h01, 5'h0D},
    '{5'h01, 5'h01, 5'h00},
    '{5'h01, 5'h01, 5'h00},
    '{5'h01, 5'h01, 5'h11},
    '{5'h01, 5'h01, 5'h00},
    '{5'h08, 5'h01, 5'h00},
    '{5'h09, 5'h01, 5'h00},
    '{5'h0B, 5'h01, 5'h00},
    '{5'h0A, 5'h01, 5'h00},
    '{5'h07, 5'h01, 5'h00},
    '{5'h06, 5'h01, 5'h00},
    '{5'h01, 5'h01, 5'h00},
    '{5'h01, 5'h01, 5'h00},
    '{5'h12, 5'h01, 5'h00},
    '{5'h13, 5'h01, 5'h00}
  };

  // Pad settings, one bit per pad
  localparam logic [PFS_NPAD-1:0] PFS_RST_FUNC0 = 22'h33F0F0;
  localparam logic [PFS_NPAD-1:0] PFS_RST_IE = 22'h0007FC;
  localparam logic [PFS_NPAD-1:0] PFS_RST_WPU = 22'h13F200;
  localparam logic [PFS_NPAD-1:0] PFS_AFT_IE = 22'h13F7FC;
  localparam logic [PFS_NPAD-1:0] PFS_AFT_WPU = 22'h13F200;
  localparam logic [PFS_NPAD-1:0] PFS_DEBUG_PADS = 22'h0000F0;
  localparam logic [PFS_NPAD-1:0] PFS_USB_PADS = 22'h0C0000;
  localparam int PFS_USB_PAD_LO = 18;

  typedef struct packed {
    logic [1:0] func;
    logic       input_buffer_on;
    logic       weak_pullup_on;
    logic       weak_pulldown_on;
  } pfs_pad_cfg_t;

  typedef struct packed {
    logic out;
    logic oe;
    logic input_buffer_on;
    logic weak_pullup_on;
    logic weak_pulldown_on;
  } pfs_pad_drive_t;

  typedef struct packed {
    logic                           booted;
    pfs_pad_cfg_t   [PFS_NPAD-1:0]  cfg;
    pfs_pad_drive_t [PFS_NPAD-1:0]  drive;
    logic           [PFS_NPAD-1:0]  router_in;
    logic           [PFS_NDIR-1:0]  direct_in;
    logic           [1:0]           usb_line_pullup_on;
  } pfs_state_t;

  function automatic pfs_state_t pfs_reset_state();
    pfs_state_t s;
    s = '0;
    for (int p = 0; p < PFS_NPAD; p++) begin
      s.cfg[p].func = PFS_RST_FUNC0[p] ? 2'h0 : 2'h1;
      s.cfg[p].input_buffer_on = PFS_RST_IE[p];
      s.cfg[p].weak_pullup_on = PFS_RST_WPU[p];
      s.drive[p].input_buffer_on = PFS_RST_IE[p];
      s.drive[p].weak_pullup_on = PFS_RST_WPU[p];
    end
    s.direct_in = PFS_DIRECT_DFLT_HI;
    return s;
  endfunction

  // Whole state while reset is held, kept constant for the reset branch
  localparam pfs_state_t PFS_RST_STATE = pfs_reset_state();

endpackage

// ### pfs_pad_function_selector.sv
// Per-pad function selector between peripherals and package pads
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1 - Each pad is joined to one of functions zero to two, picked per pad, or to none with code 3.
// R2 - Software changes a pad's function at run time by writing its configuration.
// R3 - A default-high function input sees a constant one while its pad has another function.
// R4 - A default-low function input sees a constant zero while its pad has another function.
// R5 - A pad is driven, sampled or released only as the selected function's capability allows.
// R6 - One group of functions reaches the pad through the programmable signal router.
// R7 - The debug test-access signals are wired straight to their own pad functions.
// R8 - The flash serial signals are wired straight to pad functions for 1, 2 and 4 lines.
// R9 - The fast serial signals are offered straight as pad functions for 1, 2 and 4 lines.
// R10 - Pads get one setting set at reset and a possibly different one after reset.
// R11 - Weak pull-up and weak pull-down settings enable the pad's internal resistors.
// R12 - Debug pads get input and pull-up after reset when the fuse is 0, input only when 1.
// R13 - The two USB pads default to USB, whose line pull-up replaces the generic pulls.
// R14 - With USB off the USB pads are plain pads whose pulls start off and stay writable.
// R15 - Output value and enable of an unselected function never reach the pad.
module pfs_pad_function_selector
  import pfs_pkg::*;
(
  input  wire logic                          MCLK,
  input  wire logic                          RST_N,
  input  wire pfs_pad_cfg_t [PFS_NPAD-1:0]   PAD_CFG,
  input  wire logic         [PFS_NPAD-1:0]   PAD_CFG_WE,
  output var  pfs_pad_cfg_t [PFS_NPAD-1:0]   PAD_CFG_Q,
  input  wire logic         [PFS_NPAD-1:0]   ROUTER_OUT,
  input  wire logic         [PFS_NPAD-1:0]   ROUTER_OE,
  output logic              [PFS_NPAD-1:0]   ROUTER_IN,
  input  wire logic         [PFS_NDIR-1:0]   DIRECT_OUT,
  input  wire logic         [PFS_NDIR-1:0]   DIRECT_OE,
  output logic              [PFS_NDIR-1:0]   DIRECT_IN,
  input  wire logic         [PFS_NPAD-1:0]   PAD_IN,
  output var  pfs_pad_drive_t [PFS_NPAD-1:0] PAD_DRIVE,
  input  wire logic                          FUSE_DEBUG_PADS_OFF,
  input  wire logic                          USB_FUNC_ON,
  input  wire logic         [1:0]            USB_LINE_PULLUP_ENABLE,
  output logic              [1:0]            USB_LINE_PULLUP_ON,
  output logic                               BOOTED
);

  pfs_state_t st;
  pfs_state_t next_st;

  always_comb begin
    logic [4:0] src;
    logic [2:0] cap;
    logic [4:0] dix;
    logic       sel_out;
    logic       sel_oe;
    logic       usb_pad;
    src = PFS_SRC_NONE;
    cap = PFS_CAP_NONE;
    dix = 5'h00;
    sel_out = 1'b0;
    sel_oe = 1'b0;
    usb_pad = 1'b0;
    next_st = st;
    next_st.router_in = '0;                               // see R4
    next_st.direct_in = PFS_DIRECT_DFLT_HI;               // see R3
    if (!st.booted) begin
      // First edge after release: after-reset settings, fuse taken here
      next_st.booted = 1'b1;
      for (int p = 0; p < PFS_NPAD; p++) begin
        next_st.cfg[p].input_buffer_on = PFS_AFT_IE[p];   // see R10
        next_st.cfg[p].weak_pullup_on = PFS_AFT_WPU[p]
          | (PFS_DEBUG_PADS[p] & ~FUSE_DEBUG_PADS_OFF);  // see R12
      end
    end else begin
      for (int p = 0; p < PFS_NPAD; p++) begin
        if (PAD_CFG_WE[p]) begin
          next_st.cfg[p] = PAD_CFG[p];                    // see R2
        end
      end
    end
    for (int p = 0; p < PFS_NPAD; p++) begin
      // Code 3 is unused: pad is left released with no function
      if (st.cfg[p].func == 2'h3) begin
        src = PFS_SRC_NONE;
      end else begin
        src = PFS_FUNC_SRC[p][st.cfg[p].func];            // see R1
      end
      cap = PFS_SRC_CAP[src];
      dix = src - PFS_SRC_DIR0;
      sel_out = 1'b0;
      sel_oe = 1'b0;
      if (src == PFS_SRC_ROUTER) begin
        sel_out = ROUTER_OUT[p];                          // see R6
        sel_oe = ROUTER_OE[p];
      end else if (src >= PFS_SRC_DIR0) begin
        sel_out = DIRECT_OUT[dix];                        // see R7, R8, R9
        sel_oe = DIRECT_OE[dix];
      end
      // Output-only functions cannot release the pad; input-only never drive it
      if (!cap[1]) begin
        sel_oe = 1'b0;                                    // see R5, R15
      end else if (!cap[0]) begin
        sel_oe = 1'b1;                                    // see R5
      end
      usb_pad = PFS_USB_PADS[p] & USB_FUNC_ON;
      next_st.drive[p].out = sel_out & sel_oe & ~usb_pad; // see R15
      next_st.drive[p].oe = sel_oe & ~usb_pad;
      next_st.drive[p].input_buffer_on = st.cfg[p].input_buffer_on;
      // Generic pulls are suppressed while the USB block owns the pad
      next_st.drive[p].weak_pullup_on = st.cfg[p].weak_pullup_on & ~usb_pad;    // see R11, R13
      next_st.drive[p].weak_pulldown_on = st.cfg[p].weak_pulldown_on & ~usb_pad; // see R11, R14
      // Unbuffered or non-input pads leave the peripheral at its default level
      if (cap[2] && st.cfg[p].input_buffer_on && !usb_pad) begin
        if (src == PFS_SRC_ROUTER) begin
          next_st.router_in[p] = PAD_IN[p];               // see R6
        end else begin
          next_st.direct_in[dix] = PAD_IN[p];             // see R3, R4
        end
      end
    end
    next_st.usb_line_pullup_on = USB_LINE_PULLUP_ENABLE & {2{USB_FUNC_ON}}; // see R13
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      st <= PFS_RST_STATE;                                // see R10
    end else begin
      st <= next_st;
    end
  end

  assign PAD_CFG_Q = st.cfg;
  assign PAD_DRIVE = st.drive;
  assign ROUTER_IN = st.router_in;
  assign DIRECT_IN = st.direct_in;
  assign USB_LINE_PULLUP_ON = st.usb_line_pullup_on;
  assign BOOTED = st.booted;

endmodule

`default_nettype wire

// ### pfs_sel_sva.sv
// Port checker for the pad function selector
`timescale 1ns/1ps
`default_nettype none
module pfs_sel_sva
  import pfs_pkg::*;
(
  input wire logic                        MCLK,
  input wire logic                        RST_N,
  input wire pfs_pad_cfg_t [PFS_NPAD-1:0] PAD_CFG,
  input wire logic [PFS_NPAD-1:0]         PAD_CFG_WE,
  input wire pfs_pad_cfg_t [PFS_NPAD-1:0] PAD_CFG_Q,
  input wire logic [PFS_NPAD-1:0]         ROUTER_OUT,
  input wire logic [PFS_NPAD-1:0]         ROUTER_OE,
  input wire logic [PFS_NPAD-1:0]         ROUTER_IN,
  input wire logic [PFS_NDIR-1:0]         DIRECT_IN,
  input wire logic [PFS_NPAD-1:0]         PAD_IN,
  input wire pfs_pad_drive_t [PFS_NPAD-1:0] PAD_DRIVE,
  input wire logic                        FUSE_DEBUG_PADS_OFF,
  input wire logic                        USB_FUNC_ON,
  input wire logic [1:0]                  USB_LINE_PULLUP_ENABLE,
  input wire logic [1:0]                  USB_LINE_PULLUP_ON,
  input wire logic                        BOOTED
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  property p_boot; !BOOTED |=> BOOTED; endproperty
  a_boot: assert property (p_boot) else $error("boot flag late");
  property p_fuse;
    $rose(BOOTED) |-> PAD_CFG_Q[4].weak_pullup_on == !$past(FUSE_DEBUG_PADS_OFF);
  endproperty
  a_fuse: assert property (p_fuse) else $error("debug pull wrong");
  property p_wr; BOOTED && PAD_CFG_WE[3] |=> PAD_CFG_Q[3] == $past(PAD_CFG[3]); endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_route;
    PAD_CFG_Q[0].func == 2'h1 |=> PAD_DRIVE[0].oe == $past(ROUTER_OE[0])
      && PAD_DRIVE[0].out == $past(ROUTER_OUT[0] & ROUTER_OE[0]);
  endproperty
  a_route: assert property (p_route) else $error("router drive wrong");
  property p_pin;
    PAD_CFG_Q[20].func == 2'h0 && PAD_CFG_Q[20].input_buffer_on
      |=> DIRECT_IN[PFS_D_CON_RX] == $past(PAD_IN[20]);
  endproperty
  a_pin: assert property (p_pin) else $error("rx input wrong");
  property p_hi; PAD_CFG_Q[5].func != 2'h0 |=> DIRECT_IN[PFS_D_TDI]; endproperty
  a_hi: assert property (p_hi) else $error("idle high lost");
  property p_lo; PAD_CFG_Q[7].func == 2'h2 |=> !ROUTER_IN[7]; endproperty
  a_lo: assert property (p_lo) else $error("idle low lost");
  property p_ionly; PAD_CFG_Q[4].func == 2'h0 |=> !PAD_DRIVE[4].oe; endproperty
  a_ionly: assert property (p_ionly) else $error("input pad driven");
  property p_upu;
    1'b1 |=> USB_LINE_PULLUP_ON == $past(USB_LINE_PULLUP_ENABLE & {2{USB_FUNC_ON}});
  endproperty
  a_upu: assert property (p_upu) else $error("usb pullup wrong");
  property p_upad;
    USB_FUNC_ON ##1 USB_FUNC_ON |=> !PAD_DRIVE[18].oe && !PAD_DRIVE[19].weak_pullup_on;
  endproperty
  a_upad: assert property (p_upad) else $error("usb pad driven");
endmodule
bind pfs_pad_function_selector pfs_sel_sva i_pfs_sel_sva (.MCLK, .RST_N, .PAD_CFG,
  .PAD_CFG_WE, .PAD_CFG_Q, .ROUTER_OUT, .ROUTER_OE, .ROUTER_IN, .DIRECT_IN, .PAD_IN, .PAD_DRIVE,
  .FUSE_DEBUG_PADS_OFF, .USB_FUNC_ON, .USB_LINE_PULLUP_ENABLE, .USB_LINE_PULLUP_ON, .BOOTED);
`default_nettype wire

// ### pfs_pad_model.sv
// Pad side model: outside level, pulls, else a changing pattern
`timescale 1ns/1ps
`default_nettype none
module pfs_pad_model
  import pfs_pkg::*;
(
  input  wire logic                          mclk,
  input  wire pfs_pad_drive_t [PFS_NPAD-1:0] drive,
  input  wire logic [PFS_NPAD-1:0]           ext_level,
  input  wire logic [PFS_NPAD-1:0]           ext_on,
  output logic [PFS_NPAD-1:0]                pad
);
  logic flip = 1'b0;
  always @(posedge mclk) flip <= ~flip;
  // Floating pad must not look stable
  always_comb begin
    for (int p = 0; p < PFS_NPAD; p++) begin
      pad[p] = drive[p].oe ? drive[p].out : ext_on[p] ? ext_level[p] :
        drive[p].weak_pullup_on ? 1'b1 : drive[p].weak_pulldown_on ? 1'b0 : flip ^ p[0];
    end
  end
endmodule
`default_nettype wire

// ### pfs_pad_function_selector_bench.sv
// Self-checking bench for the pad function selector
`timescale 1ns/1ps
`default_nettype none
module pfs_pad_function_selector_bench
  import pfs_pkg::*;
;
  logic mclk = 0, rst_n = 0, fuse = 0, usb = 1, go = 0, booted;
  pfs_pad_cfg_t   [PFS_NPAD-1:0] cfg = '0, cfg_q;
  pfs_pad_drive_t [PFS_NPAD-1:0] drv;
  logic [PFS_NPAD-1:0] we = '0, r_out = '0, r_oe = '0, r_in, pin, ext = '0, ext_on = '0;
  logic [PFS_NDIR-1:0] d_out = '0, d_oe = '0, d_in;
  logic [1:0]          pu_en = '0, pu_on;
  int                  err_count = 0, comparisons = 0, seed = 32'hA4CD879A;
  pfs_pad_cfg_t        c;
  pfs_pad_function_selector i_pfs_pad_function_selector (.MCLK(mclk), .RST_N(rst_n),
    .PAD_CFG(cfg), .PAD_CFG_WE(we), .PAD_CFG_Q(cfg_q), .ROUTER_OUT(r_out), .ROUTER_OE(r_oe),
    .ROUTER_IN(r_in), .DIRECT_OUT(d_out), .DIRECT_OE(d_oe), .DIRECT_IN(d_in), .PAD_IN(pin),
    .PAD_DRIVE(drv), .FUSE_DEBUG_PADS_OFF(fuse), .USB_FUNC_ON(usb),
    .USB_LINE_PULLUP_ENABLE(pu_en), .USB_LINE_PULLUP_ON(pu_on), .BOOTED(booted));
  pfs_pad_model i_pfs_pad_model (.mclk(mclk), .drive(drv), .ext_level(ext), .ext_on(ext_on),
    .pad(pin));
  initial forever #20 mclk = ~mclk;
  initial begin #400000; err_count++; results(); end
  always @(posedge mclk) if (go) begin
    r_out <= PFS_NPAD'($random(seed));
    r_oe <= PFS_NPAD'($random(seed));
    d_out <= PFS_NDIR'($random(seed));
    d_oe <= PFS_NDIR'($random(seed));
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s: %h not %h", $time, what, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input int p, input pfs_pad_cfg_t v);
    @(posedge mclk);
    cfg[p] <= v;
    we[p] <= 1'b1;
    @(posedge mclk);
    we <= '0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask
  initial begin
    for (int f = 0; f < 2; f++) begin
      @(posedge mclk);
      rst_n <= 1'b0;
      fuse <= f[0];
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(negedge mclk);
      for (int p = 0; p < PFS_NPAD; p++) begin
        c = {PFS_RST_FUNC0[p] ? 2'h0 : 2'h1, PFS_AFT_IE[p],
             PFS_AFT_WPU[p] | (PFS_DEBUG_PADS[p] & ~f[0]), 1'b0};
        check(cfg_q[p], c, "boot cfg");
      end
      check(drv[21].oe, 1'b1, "tx enable");
      go = 1'b1;
    end
    $display("boot test done");
    for (int p = 0; p < PFS_NPAD; p++) begin
      // Code 3 included: a pad with no function must still store its setting
      c = 5'($random(seed));
      wr(p, c);
      check(cfg_q[p], c, "cfg write");
    end
    $display("write test done");
    wr(20, 5'h04);
    repeat (6) begin
      @(posedge mclk);
      ext[20] <= 1'($random(seed));
      ext_on[20] <= 1'b1;
      @(posedge mclk);
      @(negedge mclk);
      check(d_in[PFS_D_CON_RX], ext[20], "rx path");
    end
    wr(20, 5'h08);
    wr(5, 5'h08);
    wr(7, 5'h10);
    check(d_in[PFS_D_CON_RX], 1'b1, "rx idle");
    check(d_in[PFS_D_TDI], 1'b1, "tdi idle");
    check(r_in[7], 1'b0, "router idle");
    $display("input test done");
    for (int v = 0; v < 8; v++) begin
      @(posedge mclk);
      pu_en <= v[1:0];
      usb <= v[2];
      @(posedge mclk);
      @(negedge mclk);
      check(pu_on, v[1:0] & {2{v[2]}}, "usb pullup");
    end
    @(posedge mclk);
    usb <= 1'b0;
    wr(18, 5'h09);
    check(drv[18].weak_pulldown_on, 1'b1, "gpio pulldown");
    $display("usb test done");
    results();
  end
endmodule
`default_nettype wire
